// File: phy_reset_link_monitor_tdr.sv
`timescale 1ns/10ps
`default_nettype none
`include "phy_ctl_defs.svh"

// What this block does
// RULE1 - strap values load after chip reset release and on loader runs, never on other resets
// RULE2 - digital reset bit runs loader: straps reloaded, registers defaulted, no xcvr reset
// RULE3 - loader reload command acts exactly like the digital reset bit
// RULE4 - global xcvr reset bit self-clears after about 102 us, no strap reload
// RULE5 - basic control soft reset resets xcvr, reads 0 when done, no strap reload
// RULE6 - leaving power-down internally generates a transceiver reset
// RULE7 - power-down entry or exit keeps register contents and straps untouched
// RULE8 - software reconfigures registers after the non-reloading resets
// RULE9 - 100 Mbps link result muxed with 10 Mbps result onto status bit and LED
// RULE10 - signal valid moves monitor to Link-Ready, waiting for auto-negotiation go-ahead
// RULE11 - go-ahead in Link-Ready enters Link-Up and enables transmit and receive
// RULE12 - with auto-negotiation off, monitor goes straight to Link-Up
// RULE13 - at least 330 ms of signal valid before Link-Ready
// RULE14 - loss of signal valid drops link at once into Link-Down
// RULE15 - in 10BASE-T the link status comes from the 10BASE-T receiver
// RULE16 - cable diagnostics are not used in fibre mode
// RULE17 - software disables crossover and auto-negotiation, forces 100 full before test
// RULE18 - those prerequisites precede setting the reflectometry enable bit
// RULE19 - with auto crossover off, crossover state picks transmit or receive pair
// RULE20 - pulse-to-reflection time is reported in the channel length field
// RULE21 - a running reflectometry test drops the active link
// RULE22 - software may restore settings afterwards and should test each pair
// RULE23 - enable bit self-clears and done sets when channel length is valid
module phy_reset_link_monitor_tdr
  import phy_ctl_pkg::*;
#(
  parameter int unsigned SETTLE_CYC = `SETTLE_CYC
) (
  input  wire logic        MCLK_I,
  input  wire logic        RST_N_I,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic        SIG_VALID_I,
  input  wire logic        LINK10_I,
  input  wire logic        AN_GO_I,
  input  wire logic        TDR_ECHO_I,
  input  wire logic [2:0]  STRAP_I,
  output logic             LINK_LED_O,
  output logic             TRX_ACTIVE_O,
  output logic             XCVR_RST_O,
  output logic             TDR_PULSE_O,
  output logic             TDR_PAIR_O
);

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    hit = (adr[7:2] == off[7:2]);
  endfunction : hit

  logic [5:0]  sync1_q, sync2_q;
  logic        ack_q, ack_d;
  logic [31:0] dat_q, dat_d;
  ctl_t        ctl_q, ctl_d;
  mdix_t       mdix_q, mdix_d;
  logic        dig_rst_q, dig_rst_d, xrst_bit_q, xrst_bit_d;
  logic [3:0]  ld_cnt_q, ld_cnt_d;
  logic [12:0] xr_cnt_q, xr_cnt_d;
  logic        xr_keep_q, xr_keep_d, xrst_out_q, xrst_out_d;
  logic        tdr_en_q, tdr_en_d, tdr_done_q, tdr_done_d;
  logic [7:0]  tdr_len_q, tdr_len_d, tdr_cnt_q, tdr_cnt_d;
  tdr_st_t     tdr_st_q, tdr_st_d;
  logic        pulse_q, pulse_d, pair_q, pair_d;
  link_st_t    lst_q, lst_d;
  logic [31:0] set_cnt_q, set_cnt_d;
  logic        link_st_q, link_st_d, up_q, up_d;
  logic        req, wr, sv, l10, echo;
  logic [2:0]  strap;

  // pin synchronisers: first stage read only by second
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      sync1_q <= 6'h00;
      sync2_q <= 6'h00;
    end else begin
      sync1_q <= {STRAP_I, TDR_ECHO_I, LINK10_I, SIG_VALID_I};
      sync2_q <= sync1_q;
    end
  end

  assign sv    = sync2_q[0];
  assign l10   = sync2_q[1];
  assign echo  = sync2_q[2];
  assign strap = sync2_q[5:3];
  assign req   = WB_CYC_I & WB_STB_I & ~ack_q;
  assign wr    = req & WB_WE_I;

  // bus, registers, resets, loader and reflectometry sequencer
  always_comb begin
    ack_d      = req;
    dat_d      = dat_q;
    ctl_d      = ctl_q;
    mdix_d     = mdix_q;
    dig_rst_d  = dig_rst_q;
    xrst_bit_d = xrst_bit_q;
    ld_cnt_d   = ld_cnt_q;
    xr_cnt_d   = xr_cnt_q;
    xr_keep_d  = xr_keep_q;
    tdr_en_d   = tdr_en_q;
    tdr_done_d = tdr_done_q;
    tdr_len_d  = tdr_len_q;
    tdr_cnt_d  = tdr_cnt_q;
    tdr_st_d   = tdr_st_q;
    pulse_d    = 1'b0;
    pair_d     = mdix_q.autox_en ? 1'b0 : mdix_q.xstate; // see RULE19
    // register reads
    if (req && !WB_WE_I) begin
      dat_d = 32'h0000_0000;
      if (hit(WB_ADR_I, `OFF_GLOBAL_RST)) begin
        dat_d[`B_DIG_RST]  = dig_rst_q;
        dat_d[`B_XCVR_RST] = xrst_bit_q;
      end
      if (hit(WB_ADR_I, `OFF_LOADER_CMD)) dat_d[`B_LD_GO] = (ld_cnt_q != 4'h0);
      if (hit(WB_ADR_I, `OFF_BASIC_CTL)) begin
        dat_d[`B_SRST]     = ctl_q.srst; // see RULE5
        dat_d[`B_SPEED100] = ctl_q.speed100;
        dat_d[`B_AN_EN]    = ctl_q.an_en;
        dat_d[`B_PDOWN]    = ctl_q.pdown;
        dat_d[`B_FDX]      = ctl_q.fdx;
      end
      if (hit(WB_ADR_I, `OFF_BASIC_STAT)) dat_d[`B_LINK_ST] = link_st_q; // see RULE9
      if (hit(WB_ADR_I, `OFF_TDR_CS)) begin
        dat_d[`B_TDR_EN]   = tdr_en_q;
        dat_d[`B_TDR_DONE] = tdr_done_q;
        dat_d[`F_TDR_LEN]  = tdr_len_q; // see RULE20
      end
      if (hit(WB_ADR_I, `OFF_MDIX)) begin
        dat_d[`B_AUTOX_EN] = mdix_q.autox_en;
        dat_d[`B_XSTATE]   = mdix_q.xstate;
      end
    end
    // register writes, lanes gated by select
    if (wr && hit(WB_ADR_I, `OFF_GLOBAL_RST) && WB_SEL_I[0]) begin
      if (WB_DAT_I[`B_DIG_RST] && ld_cnt_q == 4'h0) begin
        dig_rst_d = 1'b1;
        ld_cnt_d  = `LOADER_CYC; // see RULE2
      end
      if (WB_DAT_I[`B_XCVR_RST]) begin
        xrst_bit_d = 1'b1;
        xr_cnt_d   = 13'(`XRST_CYC); // see RULE4
        xr_keep_d  = 1'b0;
      end
    end
    if (wr && hit(WB_ADR_I, `OFF_LOADER_CMD) && WB_SEL_I[3] && WB_DAT_I[`B_LD_GO]
        && WB_DAT_I[`F_LD_CMD] == `LD_CMD_RELOAD && ld_cnt_q == 4'h0)
      ld_cnt_d = `LOADER_CYC; // see RULE3
    if (wr && hit(WB_ADR_I, `OFF_BASIC_CTL) && WB_SEL_I[1]) begin
      ctl_d.speed100 = WB_DAT_I[`B_SPEED100];
      ctl_d.an_en    = WB_DAT_I[`B_AN_EN];
      ctl_d.pdown    = WB_DAT_I[`B_PDOWN];
      ctl_d.fdx      = WB_DAT_I[`B_FDX];
      if (WB_DAT_I[`B_SRST]) begin
        ctl_d.srst = 1'b1;
        xr_cnt_d   = 13'(`XRST_CYC); // see RULE5
        xr_keep_d  = 1'b0;
      end
    end
    if (wr && hit(WB_ADR_I, `OFF_MDIX) && WB_SEL_I[1]) begin
      mdix_d.autox_en = WB_DAT_I[`B_AUTOX_EN];
      mdix_d.xstate   = WB_DAT_I[`B_XSTATE];
    end
    if (wr && hit(WB_ADR_I, `OFF_TDR_CS) && WB_SEL_I[1] && WB_DAT_I[`B_TDR_EN]
        && tdr_st_q == T_IDLE) begin
      tdr_en_d   = 1'b1; // see RULE18
      tdr_done_d = 1'b0;
    end
    // power-down exit: pulse only, registers kept
    if (ctl_q.pdown && !ctl_d.pdown && xr_cnt_d == 13'h0000) begin
      xr_cnt_d  = 13'(`XRST_CYC); // see RULE6
      xr_keep_d = 1'b1; // see RULE7
    end
    // transceiver reset timer; non-power-down resets default registers at the end
    if (xr_cnt_q != 13'h0000) begin
      xr_cnt_d = xr_cnt_q - 13'h0001;
      if (xr_cnt_q == 13'h0001) begin
        xrst_bit_d = 1'b0; // see RULE4
        if (!xr_keep_q) begin
          ctl_d  = `CTL_HW_DEFAULT; // see RULE8
          mdix_d = `MDIX_HW_DEFAULT;
        end
      end
    end
    // reflectometry sequencer
    unique case (tdr_st_q)
      T_IDLE: begin
        if (tdr_en_q) begin
          tdr_st_d  = T_PULSE;
          tdr_cnt_d = 8'h00;
          pulse_d   = 1'b1;
        end
      end
      T_PULSE: tdr_st_d = T_WAIT;
      T_WAIT: begin
        tdr_cnt_d = tdr_cnt_q + 8'h01;
        if (echo || tdr_cnt_q == `TDR_MAX_CYC) begin
          tdr_len_d  = tdr_cnt_q; // see RULE20
          tdr_en_d   = 1'b0; // see RULE23
          tdr_done_d = 1'b1;
          tdr_st_d   = T_IDLE;
        end
      end
      default: tdr_st_d = T_IDLE;
    endcase
    // loader: straps in, all registers but the transceiver reset bit to defaults, transceiver not reset
    if (ld_cnt_q != 4'h0) begin
      ld_cnt_d = ld_cnt_q - 4'h1;
      if (ld_cnt_q == 4'h1) begin
        ctl_d           = `CTL_HW_DEFAULT;
        ctl_d.an_en     = strap[0]; // see RULE1
        ctl_d.speed100  = strap[1];
        mdix_d          = `MDIX_HW_DEFAULT;
        mdix_d.autox_en = strap[2];
        dig_rst_d       = 1'b0; // see RULE2
        tdr_en_d        = 1'b0;
        tdr_done_d      = 1'b0;
        tdr_len_d       = 8'h00;
        tdr_st_d        = T_IDLE;
      end
    end
    xrst_out_d = (xr_cnt_d != 13'h0000);
  end

  // register stage; reset starts the loader so straps load after release
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ack_q      <= 1'b0;
      dat_q      <= 32'h0000_0000;
      ctl_q      <= `CTL_HW_DEFAULT;
      mdix_q     <= `MDIX_HW_DEFAULT;
      dig_rst_q  <= 1'b0;
      xrst_bit_q <= 1'b0;
      ld_cnt_q   <= `LOADER_CYC;
      xr_cnt_q   <= 13'h0000;
      xr_keep_q  <= 1'b0;
      xrst_out_q <= 1'b0;
      tdr_en_q   <= 1'b0;
      tdr_done_q <= 1'b0;
      tdr_len_q  <= 8'h00;
      tdr_cnt_q  <= 8'h00;
      tdr_st_q   <= T_IDLE;
      pulse_q    <= 1'b0;
      pair_q     <= 1'b0;
    end else begin
      ack_q      <= ack_d;
      dat_q      <= dat_d;
      ctl_q      <= ctl_d;
      mdix_q     <= mdix_d;
      dig_rst_q  <= dig_rst_d;
      xrst_bit_q <= xrst_bit_d;
      ld_cnt_q   <= ld_cnt_d;
      xr_cnt_q   <= xr_cnt_d;
      xr_keep_q  <= xr_keep_d;
      xrst_out_q <= xrst_out_d;
      tdr_en_q   <= tdr_en_d;
      tdr_done_q <= tdr_done_d;
      tdr_len_q  <= tdr_len_d;
      tdr_cnt_q  <= tdr_cnt_d;
      tdr_st_q   <= tdr_st_d;
      pulse_q    <= pulse_d;
      pair_q     <= pair_d;
    end
  end

  // link monitor next state
  always_comb begin
    lst_d     = lst_q;
    set_cnt_d = set_cnt_q;
    unique case (lst_q)
      L_DOWN: begin
        set_cnt_d = 32'h0000_0000;
        if (sv) lst_d = L_SETTLE;
      end
      L_SETTLE: begin
        set_cnt_d = set_cnt_q + 32'h0000_0001;
        if (set_cnt_q >= SETTLE_CYC - 1) // see RULE13
          lst_d = ctl_q.an_en ? L_READY : L_UP; // see RULE10 RULE12
      end
      L_READY: if (AN_GO_I) lst_d = L_UP; // see RULE11
      L_UP: lst_d = L_UP;
    endcase
    if (!sv || xrst_out_q || ctl_q.pdown || tdr_st_q != T_IDLE)
      lst_d = L_DOWN; // see RULE14 RULE21
    up_d      = (lst_d == L_UP);
    link_st_d = ctl_q.speed100 ? up_d : l10; // see RULE9 RULE15
  end

  // link monitor registers
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      lst_q     <= L_DOWN;
      set_cnt_q <= 32'h0000_0000;
      up_q      <= 1'b0;
      link_st_q <= 1'b0;
    end else begin
      lst_q     <= lst_d;
      set_cnt_q <= set_cnt_d;
      up_q      <= up_d;
      link_st_q <= link_st_d;
    end
  end

  assign WB_ACK_O     = ack_q;
  assign WB_DAT_O     = dat_q;
  assign LINK_LED_O   = link_st_q;
  assign TRX_ACTIVE_O = up_q;
  assign XCVR_RST_O   = xrst_out_q;
  assign TDR_PULSE_O  = pulse_q;
  assign TDR_PAIR_O   = pair_q;

  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RST_N_I);

  a_ack_one_cycle: assert property (ack_q |=> !ack_q) else $error("ack held");
  a_ack_after_req: assert property (req |=> ack_q) else $error("ack missing");
  a_strap_reload: assert property (ld_cnt_q == 4'h1 |=> ctl_q.an_en == $past(strap[0])
    && mdix_q.autox_en == $past(strap[2])) else $error("strap not loaded"); // see RULE1
  a_link_drop_now: assert property (!sv |=> lst_q == L_DOWN && !up_q)
    else $error("link kept"); // see RULE14
  a_settle_time: assert property ($past(lst_q) == L_SETTLE && lst_q != L_SETTLE
    && lst_q != L_DOWN |-> $past(set_cnt_q) >= SETTLE_CYC - 1)
    else $error("settled early"); // see RULE13
  a_ready_holds: assert property (lst_q == L_READY && !AN_GO_I && sv && !xrst_out_q
    && !ctl_q.pdown && tdr_st_q == T_IDLE |=> lst_q == L_READY)
    else $error("ready left"); // see RULE10
  a_ready_go: assert property (lst_q == L_READY && AN_GO_I && sv && !xrst_out_q
    && !ctl_q.pdown && tdr_st_q == T_IDLE |=> up_q) else $error("no link up"); // see RULE11
  a_link_mux: assert property (link_st_q == ($past(ctl_q.speed100) ? up_q : $past(l10)))
    else $error("link mux wrong"); // see RULE9
  a_tdr_drops: assert property (tdr_st_q != T_IDLE |=> lst_q == L_DOWN)
    else $error("link during test"); // see RULE21
  a_pd_reset: assert property ($fell(ctl_q.pdown) |-> ##1 XCVR_RST_O)
    else $error("no pd reset"); // see RULE6
  a_srst_clear: assert property (xr_cnt_q == 13'h0001 && !xr_keep_q && ld_cnt_q == 4'h0
    |=> !ctl_q.srst && !xrst_bit_q) else $error("srst stuck"); // see RULE5
  a_tdr_done: assert property (tdr_st_q == T_WAIT && echo && ld_cnt_q == 4'h0
    |=> tdr_done_q && !tdr_en_q && tdr_len_q == $past(tdr_cnt_q))
    else $error("tdr result"); // see RULE23

  c_link_up: cover property (lst_q == L_READY ##1 lst_q == L_UP);
  c_tdr_done: cover property ($rose(tdr_done_q));
  c_reload: cover property (ld_cnt_q == 4'h1 && !dig_rst_q);

endmodule : phy_reset_link_monitor_tdr
`default_nettype wire

// File: phy_ctl_defs.svh
`ifndef PHY_CTL_DEFS_SVH
`define PHY_CTL_DEFS_SVH
// register byte offsets
`define OFF_GLOBAL_RST   8'h00
`define OFF_LOADER_CMD   8'h04
`define OFF_BASIC_CTL    8'h08
`define OFF_BASIC_STAT   8'h0C
`define OFF_TDR_CS       8'h10
`define OFF_MDIX         8'h14
// field positions
`define B_DIG_RST        0
`define B_XCVR_RST       1
`define B_LD_GO          31
`define F_LD_CMD         30:28
`define LD_CMD_RELOAD    3'h7
`define B_SRST           15
`define B_SPEED100       13
`define B_AN_EN          12
`define B_PDOWN          11
`define B_FDX            8
`define B_LINK_ST        2
`define B_TDR_EN         15
`define B_TDR_DONE       8
`define F_TDR_LEN        7:0
`define B_AUTOX_EN       15
`define B_XSTATE         13
// hardwired transceiver defaults (no strap)
`define CTL_HW_DEFAULT   5'h0C
`define MDIX_HW_DEFAULT  2'h2
// timing
`define MCLK_KHZ         40000
`define SETTLE_MS        330
`define SETTLE_CYC       (`SETTLE_MS * `MCLK_KHZ)
`define XRST_US          102
`define XRST_CYC         (`XRST_US * `MCLK_KHZ / 1000)
`define LOADER_CYC       4'h8
`define TDR_MAX_CYC      8'hFF
`endif

// File: phy_ctl_pkg.sv
package phy_ctl_pkg;
  typedef enum logic [1:0] {L_DOWN, L_SETTLE, L_READY, L_UP} link_st_t;
  typedef enum logic [1:0] {T_IDLE, T_PULSE, T_WAIT} tdr_st_t;
  typedef struct packed {
    logic srst;
    logic speed100;
    logic an_en;
    logic pdown;
    logic fdx;
  } ctl_t;
  typedef struct packed {
    logic autox_en;
    logic xstate;
  } mdix_t;
endpackage : phy_ctl_pkg

// File: link_partner_model.sv
`timescale 1ns/10ps
`default_nettype none
// far end of the cable: line signal, 10 Mbps link and pulse reflections
module link_partner_model (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       sig_on_i,
  input  wire logic       link10_on_i,
  input  wire logic [7:0] echo_dly_i,
  input  wire logic       pulse_i,
  output logic            sig_valid_o,
  output logic            link10_o,
  output logic            echo_o
);
  logic [8:0] cnt_q;
  logic [8:0] dly;

  assign dly = {1'b0, echo_dly_i};

  // line levels follow the scenario; a pulse comes back after a fixed run of cable
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sig_valid_o <= 1'b0;
      link10_o    <= 1'b0;
      echo_o      <= 1'b0;
      cnt_q       <= 9'h1FF;
    end else begin
      sig_valid_o <= sig_on_i;
      link10_o    <= link10_on_i;
      echo_o      <= (cnt_q >= dly) && (cnt_q < dly + 9'h008); // open end reflects
      if (pulse_i) begin
        cnt_q <= 9'h000;
      end else if (cnt_q != 9'h1FF) begin
        cnt_q <= cnt_q + 9'h001;
      end
    end
  end
endmodule : link_partner_model
`default_nettype wire

// File: phy_reset_link_monitor_tdr_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_fail++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module phy_reset_link_monitor_tdr_tb;
  logic        clk, rst_n, cyc, stb, we, an_go, sig_on, l10_on;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat, q;
  logic [2:0]  strap;
  logic        ack, led, trx, xrst, pulse, pair, sig_valid, link10, echo;
  int          n_fail, checked, k;

  phy_reset_link_monitor_tdr #(.SETTLE_CYC(20)) dut_u (
    .MCLK_I(clk), .RST_N_I(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .SIG_VALID_I(sig_valid), .LINK10_I(link10), .AN_GO_I(an_go), .TDR_ECHO_I(echo),
    .STRAP_I(strap), .LINK_LED_O(led), .TRX_ACTIVE_O(trx), .XCVR_RST_O(xrst),
    .TDR_PULSE_O(pulse), .TDR_PAIR_O(pair));

  link_partner_model partner_u (
    .clk_i(clk), .rst_n_i(rst_n), .sig_on_i(sig_on), .link10_on_i(l10_on),
    .echo_dly_i(8'h1E), .pulse_i(pulse), .sig_valid_o(sig_valid), .link10_o(link10),
    .echo_o(echo));

  // clock generator, 25 ns period
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // closing report and verdict
  task finish_test();
    $display("checks %0d fails %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test

  // one classic wishbone cycle, held until ack is sampled
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      n_fail++;
      $display("[ERR] %0t bus timeout", $time);
      finish_test();
    end
  endtask : bus

  // read and compare masked bits
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(q & m, e)
  endtask : chk_rd

  function automatic logic pick(input int s);
    case (s)
      0:       return trx;
      1:       return xrst;
      default: return led;
    endcase
  endfunction : pick

  // bounded wait for an output level
  task automatic wt(input int s, input logic v, input int n);
    int i;
    i = 0;
    while (pick(s) !== v && i < n) begin
      @(posedge clk);
      i++;
    end
    checked++;
    if (pick(s) !== v) begin
      n_fail++;
      $display("[ERR] %0t wait on output %0d timed out", $time, s);
      finish_test();
    end
  endtask : wt

  // main sequence
  initial begin
    rst_n = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; wdat = 32'h0;
    an_go = 1'b0; sig_on = 1'b0; l10_on = 1'b0; strap = 3'h2; n_fail = 0; checked = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (12) @(posedge clk);
    chk_rd(8'h08, 32'hFFFFFFFF, 32'h00002000);
    chk_rd(8'h14, 32'hFFFFFFFF, 32'h00000000);
    chk_rd(8'h3C, 32'hFFFFFFFF, 32'h00000000);
    $display("test straps done");
    sig_on <= 1'b1;
    repeat (10) @(posedge clk);
    `CHK(trx, 1'b0)
    wt(0, 1'b1, 60);
    chk_rd(8'h0C, 32'h4, 32'h4);
    `CHK(led, 1'b1)
    sig_on <= 1'b0;
    wt(0, 1'b0, 6);
    bus(1'b1, 8'h08, 32'h3100);
    sig_on <= 1'b1;
    repeat (40) @(posedge clk);
    `CHK(trx, 1'b0)
    an_go <= 1'b1;
    wt(0, 1'b1, 4);
    an_go <= 1'b0;
    $display("test link done");
    bus(1'b1, 8'h08, 32'h2100);
    for (int p = 0; p < 2; p++) begin
      bus(1'b1, 8'h14, (p == 0) ? 32'h2000 : 32'h0);
      repeat (3) @(posedge clk);
      `CHK(pair, (p == 0) ? 1'b1 : 1'b0)
      wt(0, 1'b1, 60);
      bus(1'b1, 8'h10, 32'h8000);
      wt(0, 1'b0, 6);
      for (k = 0; k < 40; k++) begin
        bus(1'b0, 8'h10, 32'h0);
        if (q[8] === 1'b1) break;
      end
      `CHK(q[15:8], 8'h01)
      `CHK(q[7:0] >= 8'h1E && q[7:0] <= 8'h23, 1'b1)
    end
    sig_on <= 1'b0;
    bus(1'b1, 8'h08, 32'h0100);
    l10_on <= 1'b1;
    repeat (6) @(posedge clk);
    `CHK(led, 1'b1)
    chk_rd(8'h0C, 32'h4, 32'h4);
    l10_on <= 1'b0;
    wt(2, 1'b0, 6);
    $display("test reflectometry done");
    bus(1'b1, 8'h00, 32'h2);
    wt(1, 1'b1, 4);
    chk_rd(8'h00, 32'h2, 32'h2);
    wt(1, 1'b0, 5000);
    repeat (2) @(posedge clk);
    chk_rd(8'h00, 32'h2, 32'h0);
    chk_rd(8'h08, 32'hFFFFFFFF, 32'h3000);
    chk_rd(8'h14, 32'hFFFFFFFF, 32'h8000);
    bus(1'b1, 8'h08, 32'h8000);
    wt(1, 1'b1, 4);
    chk_rd(8'h08, 32'h8000, 32'h8000);
    wt(1, 1'b0, 5000);
    repeat (2) @(posedge clk);
    chk_rd(8'h08, 32'hFFFFFFFF, 32'h3000);
    bus(1'b1, 8'h00, 32'h1);
    repeat (12) @(posedge clk);
    `CHK(xrst, 1'b0)
    chk_rd(8'h08, 32'hFFFFFFFF, 32'h2000);
    chk_rd(8'h14, 32'hFFFFFFFF, 32'h0);
    chk_rd(8'h10, 32'hFFFF, 32'h0);
    bus(1'b1, 8'h14, 32'h8000);
    bus(1'b1, 8'h04, 32'hF0000000);
    repeat (12) @(posedge clk);
    chk_rd(8'h14, 32'hFFFFFFFF, 32'h0);
    chk_rd(8'h04, 32'h80000000, 32'h0);
    $display("test block resets done");
    bus(1'b1, 8'h14, 32'hA000);
    bus(1'b1, 8'h08, 32'h2800);
    repeat (4) @(posedge clk);
    `CHK(xrst, 1'b0)
    chk_rd(8'h14, 32'hFFFFFFFF, 32'hA000);
    bus(1'b1, 8'h08, 32'h2000);
    wt(1, 1'b1, 4);
    wt(1, 1'b0, 5000);
    repeat (2) @(posedge clk);
    chk_rd(8'h14, 32'hFFFFFFFF, 32'hA000);
    chk_rd(8'h08, 32'hFFFFFFFF, 32'h2000);
    $display("test power down done");
    finish_test();
  end
endmodule : phy_reset_link_monitor_tdr_tb
`default_nettype wire
